/* hw/cfr_pkg.sv */
// constants for the codec front-end configuration register bank
package cfr_pkg;
  localparam logic [11:0] ATC_OFFSET   = 12'h000;
  localparam logic [11:0] ARC_OFFSET   = 12'h004;
  localparam logic [11:0] TFC_OFFSET   = 12'h008;
  localparam logic [11:0] SIC_OFFSET   = 12'h00c;
  localparam logic [11:0] TSC_OFFSET   = 12'h010;
  localparam logic [11:0] CTL_OFFSET   = 12'h014;
  localparam logic [11:0] STA_OFFSET   = 12'h018;
  localparam logic [7:0]  REG_RESET    = 8'h00;
  localparam int          MIC_LSB      = 4;
  localparam int          VREF_BIT     = 3;
  localparam int          MUX_LSB      = 0;
  localparam int          HSET_LSB     = 5;
  localparam int          CLAMP_BIT    = 4;
  localparam int          SPK_LSB      = 0;
  localparam int          PZST_BIT     = 6;
  localparam int          ALOOP_LSB    = 3;
  localparam int          DLOOP_LSB    = 0;
  localparam int          ODB_BIT      = 4;
  localparam int          ODA_BIT      = 3;
  localparam int          DCE_BIT      = 2;
  localparam int          MCR_LSB      = 0;
  localparam int          SLOT_LSB     = 0;
  localparam logic [3:0]  MIC_OFF      = 4'h0;
  localparam logic [3:0]  MIC_MAX      = 4'h8;
  localparam logic [3:0]  MIC_BYP      = 4'hf;
  localparam logic [2:0]  HSET_OFF     = 3'h0;
  localparam logic [2:0]  HSET_MAX     = 3'h5;
  localparam logic [2:0]  HSET_BYP     = 3'h7;
  localparam logic [3:0]  SPK_OFF      = 4'h0;
  localparam logic [3:0]  SPK_CLAMP    = 4'h8;
  localparam logic [3:0]  SPK_MAX      = 4'hc;
  localparam logic [3:0]  SPK_BYP      = 4'hf;
  localparam logic [2:0]  LOOP_MAX     = 3'h4;
  localparam logic [1:0]  MUX_UNUSED   = 2'h3;
  localparam logic [31:0] UNMAPPED_RD  = 32'h00000000;
endpackage : cfr_pkg

/* hw/cfr_regs.sv */
// codec front-end configuration register bank with apb slave and field decode
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module cfr_regs (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        global_powerup_bit,
  input  wire logic        speakerphone_mode_bit,
  input  wire logic        serial_data_interface,
  input  wire logic        transmit_speech_in,
  input  wire logic        sp_idle_in,
  input  wire logic        sp_tx_active_in,
  input  wire logic        piezo_tone_a,
  input  wire logic        piezo_tone_b,
  output logic      [3:0]  mic_gain_code,
  output logic             mic_amp_on,
  output logic             mic_amp_bypass,
  output logic      [1:0]  input_mux_select,
  output logic             reference_on,
  output logic      [2:0]  handset_gain_code,
  output logic             handset_amp_on,
  output logic             handset_amp_bypass,
  output logic      [3:0]  speaker_gain_code,
  output logic             speaker_amp_on,
  output logic             speaker_amp_bypass,
  output logic             piezo_pin_a,
  output logic             piezo_pin_b,
  output logic      [2:0]  analog_loop_select,
  output logic      [2:0]  digital_loop_select,
  output logic             open_drain_enable_a,
  output logic             open_drain_enable_b,
  output logic             clock_double_enable,
  output logic      [2:0]  master_clock_rate,
  output logic      [5:0]  slot_number
);
  logic [7:0] atc_q;
  logic [7:0] arc_q;
  logic [7:0] tfc_q;
  logic [7:0] sic_q;
  logic [7:0] tsc_q;
  logic       sdi_sync1_q;
  logic       sdi_q;
  logic       speech_sync1_q;
  logic       speech_q;
  logic       spm_sync1_q;
  logic       spm_q;
  logic       pu_sync1_q;
  logic       pu_q;
  logic [3:0] piezo_sync1_q;
  logic [3:0] piezo_q;
  logic       wr_en;
  logic       rd_en;
  logic       hit;
  logic [7:0] rd_byte;
  logic [3:0] mic_f;
  logic [2:0] hset_f;
  logic [3:0] spk_f;
  logic [1:0] mux_f;
  logic [2:0] aloop_f;
  logic [2:0] dloop_f;
  logic       clamp_now;
  logic       any_amp_on;
  logic       wr_atc;
  logic       wr_arc;
  logic       wr_tfc;
  logic       wr_sic;
  logic       wr_tsc;
  logic [7:0] status_byte;

  // two-stage capture of asynchronous status inputs
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sdi_sync1_q    <= 1'b0;
      sdi_q          <= 1'b0;
      speech_sync1_q <= 1'b0;
      speech_q       <= 1'b0;
      spm_sync1_q    <= 1'b0;
      spm_q          <= 1'b0;
      pu_sync1_q     <= 1'b0;
      pu_q           <= 1'b0;
    end else begin
      sdi_sync1_q    <= serial_data_interface;
      sdi_q          <= sdi_sync1_q;
      speech_sync1_q <= transmit_speech_in;
      speech_q       <= speech_sync1_q;
      spm_sync1_q    <= speakerphone_mode_bit;
      spm_q          <= spm_sync1_q;
      pu_sync1_q     <= global_powerup_bit;
      pu_q           <= pu_sync1_q;
    end
  end

  // two-stage capture of piezo tone and speakerphone status inputs
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      piezo_sync1_q <= 4'h0;
      piezo_q       <= 4'h0;
    end else begin
      piezo_sync1_q <= {sp_tx_active_in, sp_idle_in, piezo_tone_b, piezo_tone_a};
      piezo_q       <= piezo_sync1_q;
    end
  end

  // apb decode; zero-wait answer, read data captured in the setup cycle
  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite && pstrb[0];
  assign rd_en   = psel && !penable && !pwrite;

  // per-register write strobes
  assign wr_atc  = wr_en && (paddr == cfr_pkg::ATC_OFFSET);
  assign wr_arc  = wr_en && (paddr == cfr_pkg::ARC_OFFSET);
  assign wr_tfc  = wr_en && (paddr == cfr_pkg::TFC_OFFSET);
  assign wr_sic  = wr_en && (paddr == cfr_pkg::SIC_OFFSET);
  assign wr_tsc  = wr_en && (paddr == cfr_pkg::TSC_OFFSET);
  assign status_byte = {4'h0, clamp_now, speech_q, spm_q, sdi_q};

  always_comb begin
    hit     = 1'b1;
    rd_byte = 8'h00;
    case (paddr)
      cfr_pkg::ATC_OFFSET: rd_byte = atc_q;
      cfr_pkg::ARC_OFFSET: rd_byte = arc_q;
      cfr_pkg::TFC_OFFSET: rd_byte = tfc_q;
      cfr_pkg::SIC_OFFSET: rd_byte = sic_q;
      cfr_pkg::TSC_OFFSET: rd_byte = tsc_q;
      cfr_pkg::STA_OFFSET: rd_byte = status_byte;
      default:             hit     = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !hit;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      prdata <= cfr_pkg::UNMAPPED_RD;
    end else if (rd_en) begin
      prdata <= {24'h000000, rd_byte};
    end
  end

  // register storage; each register clears to 00h on reset
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      atc_q <= cfr_pkg::REG_RESET;
    end else if (wr_atc) begin
      atc_q <= {pwdata[7:4], pwdata[3], 1'b0, pwdata[1:0]};
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      arc_q <= cfr_pkg::REG_RESET;
    end else if (wr_arc) begin
      arc_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      tfc_q <= cfr_pkg::REG_RESET;
    end else if (wr_tfc) begin
      tfc_q <= {1'b0, pwdata[6:0]};
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sic_q <= cfr_pkg::REG_RESET;
    end else if (wr_sic) begin
      sic_q <= {3'h0, pwdata[4:0]};
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      tsc_q <= cfr_pkg::REG_RESET;
    end else if (wr_tsc) begin
      tsc_q <= {2'h0, pwdata[5:0]};
    end
  end

  assign mic_f   = atc_q[cfr_pkg::MIC_LSB +: 4];
  assign mux_f   = atc_q[cfr_pkg::MUX_LSB +: 2];
  assign hset_f  = arc_q[cfr_pkg::HSET_LSB +: 3];
  assign spk_f   = arc_q[cfr_pkg::SPK_LSB +: 4];
  assign aloop_f = tfc_q[cfr_pkg::ALOOP_LSB +: 3];
  assign dloop_f = tfc_q[cfr_pkg::DLOOP_LSB +: 3];

  // clamp when speakerphone, monitoring on, speech, and gain above -9.5 dB
  assign clamp_now = spm_q && arc_q[cfr_pkg::CLAMP_BIT] && speech_q &&
                     (spk_f != cfr_pkg::SPK_OFF) && (spk_f < cfr_pkg::SPK_CLAMP);

  assign any_amp_on = mic_amp_on || handset_amp_on || speaker_amp_on;

  // microphone amplifier decode; unlisted codes power down
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      mic_gain_code  <= cfr_pkg::MIC_OFF;
      mic_amp_on     <= 1'b0;
      mic_amp_bypass <= 1'b0;
    end else begin
      mic_gain_code  <= (mic_f <= cfr_pkg::MIC_MAX) ? mic_f : cfr_pkg::MIC_OFF;
      mic_amp_on     <= (mic_f != cfr_pkg::MIC_OFF) &&
                        ((mic_f <= cfr_pkg::MIC_MAX) || (mic_f == cfr_pkg::MIC_BYP));
      mic_amp_bypass <= (mic_f == cfr_pkg::MIC_BYP);
    end
  end

  // input multiplexer; unused code falls back to pair a
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      input_mux_select <= 2'h0;
    end else begin
      input_mux_select <= (mux_f == cfr_pkg::MUX_UNUSED) ? 2'h0 : mux_f;
    end
  end

  // reference buffer: forced on, or powerup with a live amplifier
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      reference_on <= 1'b0;
    end else begin
      reference_on <= atc_q[cfr_pkg::VREF_BIT] || (pu_q && any_amp_on);
    end
  end

  // handset amplifier decode; unlisted codes power down
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      handset_gain_code  <= cfr_pkg::HSET_OFF;
      handset_amp_on     <= 1'b0;
      handset_amp_bypass <= 1'b0;
    end else begin
      handset_gain_code  <= (hset_f <= cfr_pkg::HSET_MAX) ? hset_f : cfr_pkg::HSET_OFF;
      handset_amp_on     <= (hset_f != cfr_pkg::HSET_OFF) &&
                            ((hset_f <= cfr_pkg::HSET_MAX) || (hset_f == cfr_pkg::HSET_BYP));
      handset_amp_bypass <= (hset_f == cfr_pkg::HSET_BYP);
    end
  end

  // speaker amplifier decode with speakerphone clamp
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      speaker_gain_code  <= cfr_pkg::SPK_OFF;
      speaker_amp_on     <= 1'b0;
      speaker_amp_bypass <= 1'b0;
    end else begin
      if (clamp_now) begin
        speaker_gain_code <= cfr_pkg::SPK_CLAMP;
      end else begin
        speaker_gain_code <= (spk_f <= cfr_pkg::SPK_MAX) ? spk_f : cfr_pkg::SPK_OFF;
      end
      speaker_amp_on     <= (spk_f != cfr_pkg::SPK_OFF) &&
                            ((spk_f <= cfr_pkg::SPK_MAX) || (spk_f == cfr_pkg::SPK_BYP));
      speaker_amp_bypass <= (spk_f == cfr_pkg::SPK_BYP) && !clamp_now;
    end
  end

  // loop and test selects; unlisted codes mean no test
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      analog_loop_select  <= 3'h0;
      digital_loop_select <= 3'h0;
    end else begin
      analog_loop_select  <= (aloop_f <= cfr_pkg::LOOP_MAX) ? aloop_f : 3'h0;
      digital_loop_select <= (dloop_f <= cfr_pkg::LOOP_MAX) ? dloop_f : 3'h0;
    end
  end

  // first piezo pin: idle status or tone
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      piezo_pin_a <= 1'b0;
    end else if (tfc_q[cfr_pkg::PZST_BIT]) begin
      piezo_pin_a <= piezo_q[2];
    end else begin
      piezo_pin_a <= piezo_q[0];
    end
  end

  // second piezo pin: transmit-active status or tone
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      piezo_pin_b <= 1'b0;
    end else if (tfc_q[cfr_pkg::PZST_BIT]) begin
      piezo_pin_b <= piezo_q[3];
    end else begin
      piezo_pin_b <= piezo_q[1];
    end
  end

  // serial interface fields gated by serial data interface mode
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      open_drain_enable_a <= 1'b0;
      open_drain_enable_b <= 1'b0;
      clock_double_enable <= 1'b0;
      master_clock_rate   <= 3'h0;
    end else if (sdi_q) begin
      open_drain_enable_a <= sic_q[cfr_pkg::ODA_BIT];
      open_drain_enable_b <= sic_q[cfr_pkg::ODB_BIT];
      clock_double_enable <= sic_q[cfr_pkg::DCE_BIT];
      master_clock_rate   <= sic_q[cfr_pkg::MCR_LSB +: 3];
    end else begin
      open_drain_enable_a <= 1'b0;
      open_drain_enable_b <= 1'b0;
      clock_double_enable <= 1'b0;
      master_clock_rate   <= 3'h0;
    end
  end

  // time-slot number, only in serial data interface mode
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      slot_number <= 6'h00;
    end else if (sdi_q) begin
      slot_number <= tsc_q[cfr_pkg::SLOT_LSB +: 6];
    end else begin
      slot_number <= 6'h00;
    end
  end
endmodule : cfr_regs
`default_nettype wire

/* dv/cfr_regs_monitor.sv */
// assertion checker for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module cfr_regs_monitor (
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        serial_data_interface,
  input wire logic        mic_amp_on,
  input wire logic [1:0]  input_mux_select,
  input wire logic        reference_on,
  input wire logic        handset_amp_on,
  input wire logic        speaker_amp_on,
  input wire logic [2:0]  analog_loop_select,
  input wire logic [2:0]  digital_loop_select,
  input wire logic [5:0]  slot_number,
  input wire logic        clock_double_enable
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic wr;
  assign wr = psel && penable && pwrite && pstrb[0];
  a_mic_decode: assert property (wr && paddr == cfr_pkg::ATC_OFFSET |-> ##2
    mic_amp_on == ($past(pwdata[7:4], 2) inside {[1:8], 15})) else $error("mic decode");
  a_mux_route: assert property (wr && paddr == 12'h000 && pwdata[1:0] != 2'h3 |-> ##2
    input_mux_select == $past(pwdata[1:0], 2)) else $error("mux route");
  a_ref_forced: assert property (wr && paddr == 12'h000 && pwdata[3] |-> ##2
    reference_on) else $error("reference not on");
  a_handset_decode: assert property (wr && paddr == cfr_pkg::ARC_OFFSET |-> ##2
    handset_amp_on == ($past(pwdata[7:5], 2) inside {[1:5], 7})) else $error("handset");
  a_speaker_off: assert property (wr && paddr == 12'h004 && pwdata[3:0] == 4'h0
    |-> ##2 !speaker_amp_on) else $error("speaker off");
  a_loop_select: assert property (wr && paddr == cfr_pkg::TFC_OFFSET |-> ##2
    {analog_loop_select, digital_loop_select} == $past(pwdata[5:0], 2)) else $error("loops");
  a_slot_gated: assert property (!serial_data_interface [*5] |->
    slot_number == 6'h00 && !clock_double_enable) else $error("serial gating");
  a_reset_clears: assert property ($rose(reset_n) |-> !mic_amp_on && !speaker_amp_on
    && slot_number == 6'h00) else $error("reset values");
  cover property (wr && paddr == cfr_pkg::TSC_OFFSET);
  cover property (serial_data_interface && slot_number == 6'h3f);
  cover property (reference_on && !mic_amp_on);
endmodule : cfr_regs_monitor
bind cfr_regs cfr_regs_monitor i_mon (.mclk(mclk), .reset_n(reset_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .serial_data_interface(serial_data_interface), .mic_amp_on(mic_amp_on),
  .input_mux_select(input_mux_select), .reference_on(reference_on),
  .handset_amp_on(handset_amp_on), .speaker_amp_on(speaker_amp_on),
  .analog_loop_select(analog_loop_select), .digital_loop_select(digital_loop_select),
  .slot_number(slot_number), .clock_double_enable(clock_double_enable));
`default_nettype wire

/* dv/testbench.sv */
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0] pstrb = 4'h1;
  logic global_powerup_bit = 0, speakerphone_mode_bit = 0, serial_data_interface = 0;
  logic transmit_speech_in = 0, sp_idle_in = 0, sp_tx_active_in = 0;
  logic piezo_tone_a = 0, piezo_tone_b = 0, pready, pslverr;
  logic [3:0] mic_gain_code, speaker_gain_code;
  logic [2:0] handset_gain_code, analog_loop_select, digital_loop_select, master_clock_rate;
  logic [1:0] input_mux_select;
  logic [5:0] slot_number;
  logic mic_amp_on, mic_amp_bypass, reference_on, handset_amp_on, handset_amp_bypass;
  logic speaker_amp_on, speaker_amp_bypass, piezo_pin_a, piezo_pin_b;
  logic open_drain_enable_a, open_drain_enable_b, clock_double_enable;
  int fail_count = 0, checks_done = 0;
  always #25 mclk = ~mclk;
  cfr_regs i_dut (
    .mclk                  (mclk),
    .reset_n               (reset_n),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .paddr                 (paddr),
    .pwdata                (pwdata),
    .pstrb                 (pstrb),
    .prdata                (prdata),
    .pready                (pready),
    .pslverr               (pslverr),
    .global_powerup_bit    (global_powerup_bit),
    .speakerphone_mode_bit (speakerphone_mode_bit),
    .serial_data_interface (serial_data_interface),
    .transmit_speech_in    (transmit_speech_in),
    .sp_idle_in            (sp_idle_in),
    .sp_tx_active_in       (sp_tx_active_in),
    .piezo_tone_a          (piezo_tone_a),
    .piezo_tone_b          (piezo_tone_b),
    .mic_gain_code         (mic_gain_code),
    .mic_amp_on            (mic_amp_on),
    .mic_amp_bypass        (mic_amp_bypass),
    .input_mux_select      (input_mux_select),
    .reference_on          (reference_on),
    .handset_gain_code     (handset_gain_code),
    .handset_amp_on        (handset_amp_on),
    .handset_amp_bypass    (handset_amp_bypass),
    .speaker_gain_code     (speaker_gain_code),
    .speaker_amp_on        (speaker_amp_on),
    .speaker_amp_bypass    (speaker_amp_bypass),
    .piezo_pin_a           (piezo_pin_a),
    .piezo_pin_b           (piezo_pin_b),
    .analog_loop_select    (analog_loop_select),
    .digital_loop_select   (digital_loop_select),
    .open_drain_enable_a   (open_drain_enable_a),
    .open_drain_enable_b   (open_drain_enable_b),
    .clock_double_enable   (clock_double_enable),
    .master_clock_rate     (master_clock_rate),
    .slot_number           (slot_number)
  );
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t exp %h got %h", $time, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      final_report;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wc(input logic [11:0] a, input logic [7:0] d, input int n);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {24'h0, d}, r, e);
    repeat (n) @(posedge mclk);
    #1;
  endtask : wc
  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask : rd
  task automatic t_reset;
    logic [31:0] r;
    for (int i = 0; i < 5; i++) begin
      rd(12'(i * 4), r);
      chk(32'h0, r);
    end
    chk(0, {mic_amp_on, handset_amp_on, speaker_amp_on, analog_loop_select, slot_number});
    $display("reset test done");
  endtask : t_reset
  task automatic t_mic;
    logic [31:0] r;
    for (int c = 0; c < 16; c++) begin
      if (c < 9 || c == 15) begin
        wc(12'h000, {4'(c), 1'(c), 1'b0, 2'(c % 3)}, 2);
        chk({c > 0, c == 15, (c == 15) ? 4'h0 : 4'(c)},
            {mic_amp_on, mic_amp_bypass, mic_gain_code});
        chk({2'(c % 3), 1'(c)}, {input_mux_select, reference_on});
        rd(12'h000, r);
        chk({24'h0, 4'(c), 1'(c), 1'b0, 2'(c % 3)}, r);
      end
    end
    @(posedge mclk);
    global_powerup_bit <= 1'b1;
    wc(12'h000, 8'h10, 6);
    chk(1, reference_on);
    wc(12'h000, 8'h00, 6);
    chk(0, reference_on);
    $display("transmit test done");
  endtask : t_mic
  task automatic t_rx;
    int h;
    int s;
    for (int i = 0; i < 16; i++) begin
      h = (i % 8 == 6) ? 7 : i % 8;
      s = (i == 13 || i == 14) ? 15 : i;
      wc(12'h004, {3'(h), 1'b0, 4'(s)}, 2);
      chk({h > 0, h == 7, (h == 7) ? 3'h0 : 3'(h)},
          {handset_amp_on, handset_amp_bypass, handset_gain_code});
      chk({s > 0, s == 15, (s == 15) ? 4'h0 : 4'(s)},
          {speaker_amp_on, speaker_amp_bypass, speaker_gain_code});
    end
    $display("receive test done");
  endtask : t_rx
  task automatic t_clamp;
    logic [31:0] r;
    @(posedge mclk);
    speakerphone_mode_bit <= 1'b1;
    transmit_speech_in <= 1'b1;
    wc(12'h004, 8'h13, 6);
    chk(4'h8, speaker_gain_code);
    rd(12'h018, r);
    chk(32'h0000000e, r);
    wc(12'h004, 8'h1a, 2);
    chk(4'ha, speaker_gain_code);
    wc(12'h004, 8'h03, 2);
    chk(4'h3, speaker_gain_code);
    $display("clamp test done");
  endtask : t_clamp
  task automatic t_test;
    for (int i = 0; i < 5; i++) begin
      wc(12'h008, {2'b00, 3'(i), 3'(4 - i)}, 2);
      chk({analog_loop_select, digital_loop_select}, {3'(i), 3'(4 - i)});
    end
    @(posedge mclk);
    sp_idle_in <= 1'b1;
    piezo_tone_b <= 1'b1;
    wc(12'h008, 8'h40, 6);
    chk(2'b10, {piezo_pin_a, piezo_pin_b});
    wc(12'h008, 8'h00, 2);
    chk(2'b01, {piezo_pin_a, piezo_pin_b});
    $display("test function test done");
  endtask : t_test
  task automatic t_serial;
    logic [31:0] r;
    wc(12'h010, 8'h3f, 0);
    wc(12'h00c, 8'h1f, 6);
    chk(0, {slot_number, open_drain_enable_b, open_drain_enable_a, clock_double_enable});
    @(posedge mclk);
    serial_data_interface <= 1'b1;
    repeat (6) @(posedge mclk);
    #1;
    chk(12'hfff, {slot_number, open_drain_enable_b, open_drain_enable_a,
                  clock_double_enable, master_clock_rate});
    rd(12'h010, r);
    chk(32'h3f, r);
    $display("serial test done");
  endtask : t_serial
  task automatic t_unmapped;
    logic [31:0] r;
    logic e;
    apb(1'b1, 12'h014, 32'hff, r, e);
    chk(1, e);
    apb(1'b0, 12'h014, 32'h0, r, e);
    chk(32'h0, r);
    chk(1, e);
    $display("unmapped test done");
  endtask : t_unmapped
  initial begin
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    t_reset;
    t_mic;
    t_rx;
    t_clamp;
    t_test;
    t_serial;
    t_unmapped;
    final_report;
  end
endmodule : testbench
`default_nettype wire
